//--- sim/gen_model.sv
// behavioural generator set answering the start request
// source usable UP_CYC clocks after start, gone one clock after it ends
`timescale 1ns/1ps
`default_nettype none
module gen_model #(
  parameter int UP_CYC = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        engine_on,
  input  wire logic [15:0] freq_set,
  output logic             gen_ok,
  output logic      [15:0] gen_freq
);
  int run_q;
  // cranking time before the source counts as available
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_q <= 0;
    else if (!engine_on)
      run_q <= 0;
    else if (run_q < UP_CYC)
      run_q <= run_q + 1;
  end
  assign gen_ok = (run_q == UP_CYC);
  // stopped machine measures no frequency
  assign gen_freq = gen_ok ? freq_set : 16'h0000;
endmodule // gen_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the transfer and shed timer
// bench is the bus master and utility, gen_model the generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  // short tick keeps the multi-second waits affordable
  localparam int TICK = 4;
  localparam logic [7:0]  A_TAB [6] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                                        8'h10, 8'h18};
  localparam logic [31:0] E_TAB [6] = '{32'h0, 32'hbb8, 32'hbb8,
                                        32'h1d4c0, 32'h7530, 32'h0};
  logic        sys_clk, reset, hsel, hwrite, util_ok, overload;
  logic        hreadyout, hresp, gen_ok, engine, xfer, load_ctrl;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [15:0] freq_set, gen_freq;
  logic [5:0]  shed;
  int          mismatches, n_checks;

  xfer_shed_timer #(.TICK_CYCLES(TICK), .LOADS(6)) xfer_shed_timer_i (
    .SYS_CLK(sys_clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .UTIL_OK(util_ok), .GEN_OK(gen_ok),
    .GEN_FREQ(gen_freq), .OVERLOAD(overload), .ENGINE_START(engine),
    .XFER_EMERG(xfer), .LOAD_CTRL(load_ctrl), .SHED(shed));
  gen_model gen_model_i (.clk(sys_clk), .rst(reset), .engine_on(engine),
    .freq_set(freq_set), .gen_ok(gen_ok), .gen_freq(gen_freq));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ms(input int ms);
    repeat (ms * TICK) @(posedge sys_clk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= xfer_shed_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // timer cleared by a brief healthy spell, then one shed awaited
  task automatic step(input logic [15:0] f, input logic ol,
                      input int ms, input logic [5:0] e);
    freq_set <= 16'h1770;
    overload <= 1'b0;
    wait_ms(2);
    freq_set <= f;
    overload <= ol;
    wait_ms(ms - 2);
    chk(32'(shed), 32'({e[4:0], 1'b0}));
    wait_ms(4);
    chk(32'(shed), 32'(e));
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end

  initial
  begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    util_ok = 1'b1;
    overload = 1'b0;
    freq_set = 16'h1770;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) rchk(A_TAB[i], E_TAB[i]);
    bus(1'b1, 8'h04, 32'h14);
    rchk(8'h04, 32'hbb8);
    bus(1'b1, 8'h00, 32'h2);
    bus(1'b1, 8'h04, 32'h14);
    bus(1'b1, 8'h08, 32'h14);
    bus(1'b1, 8'h0c, 32'h28);
    bus(1'b1, 8'h10, 32'h50);
    rchk(8'h0c, 32'h28);
    util_ok <= 1'b0;
    wait_ms(40);
    chk(32'(engine), 32'h0);
    util_ok <= 1'b1;
    bus(1'b1, 8'h00, 32'h3);
    util_ok <= 1'b0;
    wait_ms(10);
    util_ok <= 1'b1;
    wait_ms(30);
    chk(32'(engine), 32'h0);
    util_ok <= 1'b0;
    wait_ms(18);
    chk(32'(engine), 32'h0);
    wait_ms(4);
    chk(32'(engine), 32'h1);
    wait_ms(16);
    chk(32'(xfer), 32'h0);
    wait_ms(7);
    chk(32'(xfer), 32'h1);
    chk(32'(load_ctrl), 32'h0);
    freq_set <= 16'h170c;
    wait_ms(100);
    chk(32'(shed), 32'h0);
    step(16'h16da, 1'b0, 5400, 6'h20);
    step(16'h1644, 1'b0, 2150, 6'h30);
    step(16'h15e0, 1'b0, 850, 6'h38);
    step(16'h1518, 1'b0, 225, 6'h3c);
    step(16'h1450, 1'b0, 18, 6'h3e);
    freq_set <= 16'h1518;
    wait_ms(30);
    step(16'h1518, 1'b0, 56, 6'h3f);
    freq_set <= 16'h1770;
    util_ok <= 1'b1;
    wait_ms(38);
    chk(32'(xfer), 32'h1);
    wait_ms(4);
    chk(32'(xfer), 32'h0);
    chk(32'(shed), 32'h0);
    util_ok <= 1'b0;
    wait_ms(60);
    chk(32'(xfer), 32'h1);
    // overload flag stands for a threshold set above capacity
    step(16'h1770, 1'b1, 80, 6'h20);
    step(16'h1770, 1'b1, 80, 6'h30);
    step(16'h1770, 1'b1, 40, 6'h38);
    complete_run();
  end
endmodule // tb
`default_nettype wire

//--- sim/xfer_shed_monitor.sv
// concurrent checks on the transfer and shed timer ports
// bound into xfer_shed_timer, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module xfer_shed_monitor #(
  parameter int LOADS = 6
) (
  input wire logic             SYS_CLK,
  input wire logic             RESET,
  input wire logic             HREADYOUT,
  input wire logic             HRESP,
  input wire logic             UTIL_OK,
  input wire logic             GEN_OK,
  input wire logic [15:0]      GEN_FREQ,
  input wire logic             OVERLOAD,
  input wire logic             ENGINE_START,
  input wire logic             XFER_EMERG,
  input wire logic             LOAD_CTRL,
  input wire logic [LOADS-1:0] SHED
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  bus_ok_a: assert property (HREADYOUT && !HRESP)
    else $error("bus slave not ready or not okay");
  start_a: assert property
    ($rose(ENGINE_START) |-> !$past(UTIL_OK, 3))
    else $error("engine start without utility loss");
  xfer_a: assert property
    ($rose(XFER_EMERG) |-> ENGINE_START && $past(GEN_OK, 2))
    else $error("transfer without generator");
  back_a: assert property
    ($fell(XFER_EMERG) |->
      $past(UTIL_OK, 2) ##[0:2] (LOAD_CTRL && !ENGINE_START))
    else $error("bad return to utility");
  lc_a: assert property
    ($rose(XFER_EMERG) |=> (!LOAD_CTRL) [*8])
    else $error("load control not held off");
  idle_a: assert property
    // shed count clears a cycle after the drop, outputs a cycle later
    (!XFER_EMERG && !$past(XFER_EMERG) && !$past(XFER_EMERG, 2)
      |-> SHED == '0)
    else $error("shed while on utility");
  order_a: assert property
    ((((~SHED) + 1'b1) & (~SHED)) == '0)
    else $error("shed order broken");
  step_a: assert property
    (XFER_EMERG && $past(XFER_EMERG) |->
      $countones(SHED ^ $past(SHED)) < 2)
    else $error("more than one load moved");
  cause_a: assert property
    ($countones(SHED) > $countones($past(SHED)) |->
      $past(GEN_FREQ, 3) < xfer_shed_pkg::F_NEVER || $past(OVERLOAD, 3))
    else $error("shed without a cause");
endmodule // xfer_shed_monitor

bind xfer_shed_timer xfer_shed_monitor #(.LOADS(LOADS))
  xfer_shed_monitor_i (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .UTIL_OK(UTIL_OK), .GEN_OK(GEN_OK),
  .GEN_FREQ(GEN_FREQ), .OVERLOAD(OVERLOAD),
  .ENGINE_START(ENGINE_START), .XFER_EMERG(XFER_EMERG),
  .LOAD_CTRL(LOAD_CTRL), .SHED(SHED));
`default_nettype wire

//--- verilog/xfer_shed_pkg.sv
// constants, types and register map of the transfer and shed timer
// assumes a 200 MHz system clock and a millisecond time base
`default_nettype none
package xfer_shed_pkg;
  // time base
  localparam int CLK_HZ      = 200_000_000;
  localparam int TICK_HZ     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int MS_PER_S    = 1000;
  localparam int MS_PER_MIN  = 60_000;
  // factory delays, in their printed units
  localparam int START_DLY_S   = 3;
  localparam int NE_DLY_S      = 3;
  localparam int EN_DLY_MIN    = 2;
  localparam int LC_DLY_MIN    = 5;
  localparam int ADD_DLY_S     = 60;
  localparam int OL_BASE_S     = 30;
  localparam logic [19:0] START_DLY_MS = 20'(START_DLY_S * MS_PER_S);
  localparam logic [19:0] NE_DLY_MS    = 20'(NE_DLY_S * MS_PER_S);
  localparam logic [19:0] EN_DLY_MS    = 20'(EN_DLY_MIN * MS_PER_MIN);
  localparam logic [19:0] LC_DLY_MS    = 20'(LC_DLY_MIN * MS_PER_MIN);
  localparam logic [19:0] ADD_DLY_MS   = 20'(ADD_DLY_S * MS_PER_S);
  localparam logic [19:0] OL_BASE_MS   = 20'(OL_BASE_S * MS_PER_S);
  // under-frequency table, frequency in units of 0.01 Hz, waits in ms
  localparam logic [15:0] F_NEVER = 16'h170c; // 59.00 Hz
  localparam logic [15:0] F_P1    = 16'h16da; // 58.50 Hz
  localparam logic [15:0] F_P2    = 16'h1644; // 57.00 Hz
  localparam logic [15:0] F_P3    = 16'h15e0; // 56.00 Hz
  localparam logic [15:0] F_P4    = 16'h1518; // 54.00 Hz
  localparam logic [15:0] F_FAST  = 16'h1482; // 52.50 Hz
  localparam logic [19:0] W_P1    = 20'h01518; // 5.4 s
  localparam logic [19:0] W_P2    = 20'h010cc; // 4.3 s
  localparam logic [19:0] W_P3    = 20'h00d48; // 3.4 s
  localparam logic [19:0] W_P4    = 20'h00708; // 1.8 s
  localparam logic [19:0] W_FAST  = 20'h0012c; // 0.3 s
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_START  = 8'h04;
  localparam logic [7:0] ADDR_NE     = 8'h08;
  localparam logic [7:0] ADDR_EN     = 8'h0c;
  localparam logic [7:0] ADDR_OLBASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int CTRL_LINK_BIT   = 0;
  localparam int CTRL_UNLOCK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_ENGINE    = 3;
  localparam int ST_EMERG     = 4;
  localparam int ST_LOADCTL   = 5;
  localparam int ST_SHED_LSB  = 8;
  localparam int ST_FREQ_LSB  = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [2:0] {
    ST_NORMAL      = 3'b000,
    ST_START_WAIT  = 3'b001,
    ST_GEN_WAIT    = 3'b010,
    ST_ON_EMERG    = 3'b011,
    ST_RETURN_WAIT = 3'b100
  } xfer_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_phase_t;

  typedef struct packed {
    logic [19:0] start_ms;
    logic [19:0] ne_ms;
    logic [19:0] en_ms;
    logic [19:0] ol_ms;
  } delay_cfg_t;
endpackage
`default_nettype wire

//--- verilog/xfer_shed_timer.sv
// transfer sequencing, load control delay and load shed timing
// assumes synchronous inputs and a single AHB-Lite master
//
// Summary of operation
// - shed wait derived from frequency droop; bigger droop, shorter wait
// - 60 Hz waits 5.4/4.3/3.4/1.8 s at 58.5/57/56/54 Hz
// - no frequency shed above 59 Hz; 0.3 s below 52.5 Hz
// - persisting condition shortens the wait: before each further shed for frequency, every second shed for overload
// - under-frequency shortening steeper than overload shortening
// - transfer delays reset to factory values, writable only when unlocked
// - transfer delays operate only with the transfer switch linked
// - wait 3 s after utility loss before engine start request
// - wait 3 s after emergency available before transfer to emergency
// - wait 2 minutes after utility return before transfer back
// - load control output off for fixed 5 minutes after transfer
// - shed highest priority numbers first, re-add when loading allows
`timescale 1ns/1ps
`default_nettype none
module xfer_shed_timer #(
  parameter int TICK_CYCLES = xfer_shed_pkg::TICK_CYCLES,
  parameter int LOADS       = 6
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RESET,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  input  wire logic              UTIL_OK,
  input  wire logic              GEN_OK,
  input  wire logic [15:0]       GEN_FREQ,
  input  wire logic              OVERLOAD,
  output logic                   ENGINE_START,
  output logic                   XFER_EMERG,
  output logic                   LOAD_CTRL,
  output logic      [LOADS-1:0]  SHED
);
  xfer_shed_pkg::bus_phase_t  ph_q;
  xfer_shed_pkg::delay_cfg_t  cfg_q;
  xfer_shed_pkg::xfer_state_t state_q;
  xfer_shed_pkg::xfer_state_t state_d;
  logic [1:0]  ctrl_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;
  logic [31:0] status;
  logic [31:0] pre_q;
  logic        tick;
  logic [19:0] seq_cnt_q;
  logic [19:0] seq_lim;
  logic        seq_run;
  logic [19:0] lc_cnt_q;
  logic        lc_done_q;
  logic        engine_q;
  logic        emerg_q;
  logic        load_ctrl_q;
  logic [19:0] shed_cnt_q;
  logic [19:0] add_cnt_q;
  logic [3:0]  shed_num_q;
  logic [19:0] shed_wait;
  logic        uf_act;
  logic        cond;
  logic        linked;
  logic        addr_phase;

  // under-frequency base wait by droop band
  function automatic logic [19:0] uf_wait(input logic [15:0] f);
    if (f < xfer_shed_pkg::F_FAST)
      uf_wait = xfer_shed_pkg::W_FAST;
    else if (f <= xfer_shed_pkg::F_P4)
      uf_wait = xfer_shed_pkg::W_P4;
    else if (f <= xfer_shed_pkg::F_P3)
      uf_wait = xfer_shed_pkg::W_P3;
    else if (f <= xfer_shed_pkg::F_P2)
      uf_wait = xfer_shed_pkg::W_P2;
    else
      uf_wait = xfer_shed_pkg::W_P1;
  endfunction

  function automatic logic engine_on(input xfer_shed_pkg::xfer_state_t s);
    engine_on = (s == xfer_shed_pkg::ST_GEN_WAIT) ||
                (s == xfer_shed_pkg::ST_ON_EMERG) ||
                (s == xfer_shed_pkg::ST_RETURN_WAIT);
  endfunction

  function automatic logic on_emerg(input xfer_shed_pkg::xfer_state_t s);
    on_emerg = (s == xfer_shed_pkg::ST_ON_EMERG) ||
               (s == xfer_shed_pkg::ST_RETURN_WAIT);
  endfunction

  // bus slave: zero wait, always okay
  assign HREADYOUT  = 1'b1;
  assign HRESP      = xfer_shed_pkg::HRESP_OKAY;
  assign HRDATA     = hrdata_q;
  assign addr_phase = HSEL && HREADY &&
                      (HTRANS == xfer_shed_pkg::HTRANS_NONSEQ);
  assign linked     = ctrl_q[xfer_shed_pkg::CTRL_LINK_BIT];

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      ph_q <= '0;
    else if (HREADY)
      ph_q <= '{valid: addr_phase, write: HWRITE, addr: HADDR[7:0]};
  end

  always_comb
  begin
    status = '0;
    status[xfer_shed_pkg::ST_STATE_LSB +: 3] = state_q;
    status[xfer_shed_pkg::ST_ENGINE]  = engine_q;
    status[xfer_shed_pkg::ST_EMERG]   = emerg_q;
    status[xfer_shed_pkg::ST_LOADCTL] = load_ctrl_q;
    status[xfer_shed_pkg::ST_SHED_LSB +: 4]  = shed_num_q;
    status[xfer_shed_pkg::ST_FREQ_LSB +: 16] = GEN_FREQ;
  end

  always_comb
  begin
    case (HADDR[7:0])
      xfer_shed_pkg::ADDR_CTRL:   rd_val = {30'h0, ctrl_q};
      xfer_shed_pkg::ADDR_START:  rd_val = {12'h0, cfg_q.start_ms};
      xfer_shed_pkg::ADDR_NE:     rd_val = {12'h0, cfg_q.ne_ms};
      xfer_shed_pkg::ADDR_EN:     rd_val = {12'h0, cfg_q.en_ms};
      xfer_shed_pkg::ADDR_OLBASE: rd_val = {12'h0, cfg_q.ol_ms};
      xfer_shed_pkg::ADDR_STATUS: rd_val = status;
      default:                    rd_val = 32'h0;
    endcase
  end

  // read data sampled in the address phase
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      hrdata_q <= 32'h0;
    else if (addr_phase && !HWRITE)
      hrdata_q <= rd_val;
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      ctrl_q <= xfer_shed_pkg::CTRL_RESET;
    else if (ph_q.valid && ph_q.write &&
             ph_q.addr == xfer_shed_pkg::ADDR_CTRL)
      ctrl_q <= HWDATA[1:0];
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cfg_q.start_ms <= xfer_shed_pkg::START_DLY_MS;
      cfg_q.ne_ms    <= xfer_shed_pkg::NE_DLY_MS;
      cfg_q.en_ms    <= xfer_shed_pkg::EN_DLY_MS;
      cfg_q.ol_ms    <= xfer_shed_pkg::OL_BASE_MS;
    end
    else if (ph_q.valid && ph_q.write &&
             ctrl_q[xfer_shed_pkg::CTRL_UNLOCK_BIT])
    begin
      case (ph_q.addr)
        xfer_shed_pkg::ADDR_START:  cfg_q.start_ms <= HWDATA[19:0];
        xfer_shed_pkg::ADDR_NE:     cfg_q.ne_ms    <= HWDATA[19:0];
        xfer_shed_pkg::ADDR_EN:     cfg_q.en_ms    <= HWDATA[19:0];
        xfer_shed_pkg::ADDR_OLBASE: cfg_q.ol_ms    <= HWDATA[19:0];
        default:                    cfg_q          <= cfg_q;
      endcase
    end
  end

  // millisecond time base; long count, shorten for simulation
  assign tick = (pre_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      pre_q <= 32'h0;
    else if (tick)
      pre_q <= 32'h0;
    else
      pre_q <= pre_q + 32'h1;
  end

  // transfer sequence
  always_comb
  begin
    state_d = state_q;
    seq_run = 1'b0;
    seq_lim = 20'h0;
    case (state_q)
      xfer_shed_pkg::ST_NORMAL:
        if (linked && !UTIL_OK)
          state_d = xfer_shed_pkg::ST_START_WAIT;
      xfer_shed_pkg::ST_START_WAIT:
      begin
        seq_run = 1'b1;
        seq_lim = cfg_q.start_ms;
        if (UTIL_OK)
          state_d = xfer_shed_pkg::ST_NORMAL;
        else if (seq_cnt_q >= seq_lim)
          state_d = xfer_shed_pkg::ST_GEN_WAIT;
      end
      xfer_shed_pkg::ST_GEN_WAIT:
      begin
        seq_run = GEN_OK;
        seq_lim = cfg_q.ne_ms;
        if (UTIL_OK)
          state_d = xfer_shed_pkg::ST_NORMAL;
        else if (GEN_OK && seq_cnt_q >= seq_lim)
          state_d = xfer_shed_pkg::ST_ON_EMERG;
      end
      xfer_shed_pkg::ST_ON_EMERG:
        if (UTIL_OK)
          state_d = xfer_shed_pkg::ST_RETURN_WAIT;
      xfer_shed_pkg::ST_RETURN_WAIT:
      begin
        seq_run = 1'b1;
        seq_lim = cfg_q.en_ms;
        if (!UTIL_OK)
          state_d = xfer_shed_pkg::ST_ON_EMERG;
        else if (seq_cnt_q >= seq_lim)
          state_d = xfer_shed_pkg::ST_NORMAL;
      end
      default:
        state_d = xfer_shed_pkg::ST_NORMAL;
    endcase
    if (!linked)
      state_d = xfer_shed_pkg::ST_NORMAL;
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      state_q <= xfer_shed_pkg::ST_NORMAL;
    else
      state_q <= state_d;
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      seq_cnt_q <= 20'h0;
    else if (state_d != state_q || !seq_run)
      seq_cnt_q <= 20'h0;
    else if (tick && seq_cnt_q < seq_lim)
      seq_cnt_q <= seq_cnt_q + 20'h1;
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      engine_q <= 1'b0;
      emerg_q  <= 1'b0;
    end
    else
    begin
      engine_q <= engine_on(state_d);
      emerg_q  <= on_emerg(state_d);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      lc_cnt_q  <= 20'h0;
      lc_done_q <= 1'b0;
    end
    else if (!on_emerg(state_q))
    begin
      lc_cnt_q  <= 20'h0;
      lc_done_q <= 1'b0;
    end
    else if (lc_cnt_q >= xfer_shed_pkg::LC_DLY_MS)
      lc_done_q <= 1'b1;
    else if (tick)
      lc_cnt_q <= lc_cnt_q + 20'h1;
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      load_ctrl_q <= 1'b0;
    else
      load_ctrl_q <= on_emerg(state_q) ? lc_done_q : 1'b1;
  end

  // never shed for frequency at or above 59 Hz
  assign uf_act = emerg_q && (GEN_FREQ < xfer_shed_pkg::F_NEVER);
  assign cond   = uf_act || (emerg_q && OVERLOAD);

  // droop, or ol_ms when only overload holds, sets the base wait; shift per shed
  always_comb
  begin
    // halve per shed for frequency, every second shed for load
    if (uf_act)
      shed_wait = uf_wait(GEN_FREQ) >> shed_num_q;
    else
      shed_wait = cfg_q.ol_ms >> shed_num_q[3:1];
    if (shed_wait == 20'h0)
      shed_wait = 20'h1;
  end

  // timer resets once condition clears; acceleration eases only as loads are re-added
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      shed_cnt_q <= 20'h0;
    else if (!cond || shed_cnt_q >= shed_wait)
      shed_cnt_q <= 20'h0;
    else if (tick)
      shed_cnt_q <= shed_cnt_q + 20'h1;
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      add_cnt_q <= 20'h0;
    else if (cond || shed_num_q == 4'h0 ||
             add_cnt_q >= xfer_shed_pkg::ADD_DLY_MS)
      add_cnt_q <= 20'h0;
    else if (tick)
      add_cnt_q <= add_cnt_q + 20'h1;
  end

  // shed count grows on expiry, shrinks after quiet period
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      shed_num_q <= 4'h0;
    else if (!emerg_q)
      shed_num_q <= 4'h0;
    else if (cond && shed_cnt_q >= shed_wait && shed_num_q < 4'(LOADS))
      shed_num_q <= shed_num_q + 4'h1;
    else if (!cond && add_cnt_q >= xfer_shed_pkg::ADD_DLY_MS &&
             shed_num_q != 4'h0)
      shed_num_q <= shed_num_q - 4'h1;
  end

  // larger index, lower priority, shed first
  for (genvar i = 0; i < LOADS; i++)
  begin : g_shed
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
      if (RESET)
        SHED[i] <= 1'b0;
      else
        SHED[i] <= (5'(i) + 5'(shed_num_q)) >= 5'(LOADS);
    end
  end

  assign ENGINE_START = engine_q;
  assign XFER_EMERG   = emerg_q;
  assign LOAD_CTRL    = load_ctrl_q;
endmodule // xfer_shed_timer
`default_nettype wire
